//--- rxs_stats_gen.sv
// receive statistics increment generator with wishbone control registers
//
// Implementation choices: the register offsets and the Wishbone register port.
module rxs_stats_gen #(
   parameter bit MAC_BUILD = 1'b1
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // receive events, one or two packet ends per cycle
   input  wire logic [5:0]  rx_bytes,
   input  wire logic        rx_eop0,
   input  wire logic [13:0] rx_len0,
   input  wire logic        rx_fcs_bad0,
   input  wire logic        rx_err0,
   input  wire logic        rx_eop1,
   input  wire logic [13:0] rx_len1,
   input  wire logic        rx_fcs_bad1,
   input  wire logic        rx_err1,
   input  wire logic        rx_fifo_ovf,
   input  wire logic        rx_fifo_unf,
   // increments and interrupt
   output logic             fifo_err,
   output logic [1:0]       total_pkts,
   output logic             good_pkts,
   output logic [5:0]       total_bytes,
   output logic [13:0]      good_bytes,
   output logic [1:0]       small_pkts,
   output logic             jabber,
   output logic             large_pkts,
   output logic             oversize,
   output logic [1:0]       undersize,
   output logic             toolong,
   output logic [1:0]       fragment,
   output logic [7:0]       hist_inc,
   output logic             irq,
   // wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic in_range(input logic [13:0] v,
                                     input logic [13:0] lo,
                                     input logic [13:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  sel);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            lane_merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic        fifo_err_r,  fifo_err_nxt;
   logic [1:0]  total_r,     total_nxt;
   logic        good_r,      good_nxt;
   logic [5:0]  tbytes_r,    tbytes_nxt;
   logic [13:0] gbytes_r,    gbytes_nxt;
   logic [1:0]  small_r,     small_nxt;
   logic        jabber_r,    jabber_nxt;
   logic        large_r,     large_nxt;
   logic        over_r,      over_nxt;
   logic [1:0]  under_r,     under_nxt;
   logic        long_r,      long_nxt;
   logic [1:0]  frag_r,      frag_nxt;
   logic [7:0]  hist_r,      hist_nxt;
   logic [13:0] max_len_r,   max_len_nxt;
   logic [7:0]  min_len_r,   min_len_nxt;
   logic [4:0]  irq_st_r,    irq_st_nxt;
   logic [4:0]  irq_msk_r,   irq_msk_nxt;
   logic        irq_r,       irq_nxt;
   logic        ack_r,       ack_nxt;
   logic [31:0] dat_r,       dat_nxt;

   logic        keep0;
   logic        keep1;
   logic        good0;
   logic [13:0] min_len;
   logic [4:0]  irq_set;
   logic [4:0]  irq_clr;
   logic        wb_req;
   logic [31:0] merged;

   // ----------------------------------------
   // classification
   // ----------------------------------------
   always_comb begin
      min_len      = {6'h00, min_len_r};
      keep0        = rx_eop0 && (rx_len0 >= rxs_pkg::DROP_LEN);               // [R7]
      keep1        = rx_eop1 && (rx_len1 >= rxs_pkg::DROP_LEN);               // [R7]
      // slot 1 only ever holds a short packet, so it is never counted good
      good0        = keep0 && !rx_fcs_bad0 && !rx_err0 &&
                     (rx_len0 >= min_len) && (rx_len0 <= max_len_r);
      fifo_err_nxt = 1'b0;
      total_nxt    = 2'h0;
      good_nxt     = 1'b0;
      tbytes_nxt   = 6'h00;
      gbytes_nxt   = 14'h0000;
      small_nxt    = 2'h0;
      jabber_nxt   = 1'b0;
      large_nxt    = 1'b0;
      over_nxt     = 1'b0;
      under_nxt    = 2'h0;
      long_nxt     = 1'b0;
      frag_nxt     = 2'h0;
      hist_nxt     = 8'h00;
      if (!MAC_BUILD) begin
         // error stays up until the port is reset, the outside must do so
         fifo_err_nxt = fifo_err_r || rx_fifo_ovf || rx_fifo_unf;           // [R1] [R2] [R17]
      end else begin
         total_nxt  = {1'b0, keep0} + {1'b0, keep1};                          // [R3]
         good_nxt   = good0;                                                  // [R4]
         tbytes_nxt = rx_bytes;                                               // [R5]
         gbytes_nxt = good0 ? rx_len0 : 14'h0000;                             // [R6]
         small_nxt  = {1'b0, keep0 && (rx_len0 < rxs_pkg::SMALL_LEN)} +
                      {1'b0, keep1 && (rx_len1 < rxs_pkg::SMALL_LEN)};        // [R7]
         jabber_nxt = keep0 && (rx_len0 > max_len_r) && rx_fcs_bad0;          // [R8]
         large_nxt  = keep0 && (rx_len0 > rxs_pkg::LARGE_LEN);               // [R9]
         over_nxt   = keep0 && (rx_len0 > max_len_r) && !rx_fcs_bad0;         // [R10]
         long_nxt   = keep0 && (rx_len0 > max_len_r);                         // [R12]
         under_nxt  = {1'b0, keep0 && (rx_len0 < min_len) && !rx_fcs_bad0} +
                      {1'b0, keep1 && (rx_len1 < min_len) && !rx_fcs_bad1};   // [R11]
         frag_nxt   = {1'b0, keep0 && (rx_len0 < min_len) && rx_fcs_bad0} +
                      {1'b0, keep1 && (rx_len1 < min_len) && rx_fcs_bad1};    // [R13]
         for (int i = 0; i < rxs_pkg::HIST_N; i++) begin
            hist_nxt[i] = keep0 &&
                          in_range(rx_len0, rxs_pkg::HIST_LO[i], rxs_pkg::HIST_HI[i]); // [R14] [R15] [R16] [R19]
         end
      end
   end

   // every increment but fifo_err is rebuilt from zero each cycle, so only fifo_err can linger
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fifo_err_r <= 1'b0;
         total_r    <= 2'h0;
         good_r     <= 1'b0;
         tbytes_r   <= 6'h00;
         gbytes_r   <= 14'h0000;
         small_r    <= 2'h0;
         jabber_r   <= 1'b0;
         large_r    <= 1'b0;
         over_r     <= 1'b0;
         under_r    <= 2'h0;
         long_r     <= 1'b0;
         frag_r     <= 2'h0;
         hist_r     <= 8'h00;
      end else begin                                                          // [R18]
         fifo_err_r <= fifo_err_nxt;
         total_r    <= total_nxt;
         good_r     <= good_nxt;
         tbytes_r   <= tbytes_nxt;
         gbytes_r   <= gbytes_nxt;
         small_r    <= small_nxt;
         jabber_r   <= jabber_nxt;
         large_r    <= large_nxt;
         over_r     <= over_nxt;
         under_r    <= under_nxt;
         long_r     <= long_nxt;
         frag_r     <= frag_nxt;
         hist_r     <= hist_nxt;
      end
   end

   // ----------------------------------------
   // registers and interrupt
   // ----------------------------------------
   always_comb begin
      wb_req      = wb_cyc_i && wb_stb_i && !ack_r;
      ack_nxt     = wb_req;
      dat_nxt     = dat_r;
      max_len_nxt = max_len_r;
      min_len_nxt = min_len_r;
      irq_msk_nxt = irq_msk_r;
      irq_clr     = 5'h00;
      merged      = 32'h0000_0000;
      irq_set     = 5'h00;
      irq_set[rxs_pkg::IRQ_FIFO]  = fifo_err_nxt;
      irq_set[rxs_pkg::IRQ_JAB]   = jabber_nxt;
      irq_set[rxs_pkg::IRQ_LONG]  = long_nxt;
      irq_set[rxs_pkg::IRQ_FRAG]  = |frag_nxt;
      irq_set[rxs_pkg::IRQ_UNDER] = |under_nxt;
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            rxs_pkg::ADR_MAX_LEN: begin
               merged      = lane_merge({18'h00000, max_len_r}, wb_dat_i, wb_sel_i);
               max_len_nxt = merged[13:0];
            end
            rxs_pkg::ADR_MIN_LEN: begin
               merged      = lane_merge({24'h000000, min_len_r}, wb_dat_i, wb_sel_i);
               min_len_nxt = merged[7:0];
            end
            rxs_pkg::ADR_IRQ_ST: begin
               merged  = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
               irq_clr = merged[4:0];
            end
            rxs_pkg::ADR_IRQ_MSK: begin
               merged      = lane_merge({27'h0000000, irq_msk_r}, wb_dat_i, wb_sel_i);
               irq_msk_nxt = merged[4:0];
            end
            default: begin
               merged = 32'h0000_0000;
            end
         endcase
      end
      if (wb_req) begin
         case (wb_adr_i)
            rxs_pkg::ADR_MAX_LEN: dat_nxt = {18'h00000, max_len_r};
            rxs_pkg::ADR_MIN_LEN: dat_nxt = {24'h000000, min_len_r};
            rxs_pkg::ADR_IRQ_ST:  dat_nxt = {27'h0000000, irq_st_r};
            rxs_pkg::ADR_IRQ_MSK: dat_nxt = {27'h0000000, irq_msk_r};
            default:              dat_nxt = 32'h0000_0000;
         endcase
      end
      // a new event in the clearing cycle survives the clear
      irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;
      irq_nxt    = |(irq_st_nxt & irq_msk_nxt);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         max_len_r <= rxs_pkg::RST_MAX_LEN;
         min_len_r <= rxs_pkg::RST_MIN_LEN;
         irq_st_r  <= rxs_pkg::RST_IRQ;
         irq_msk_r <= rxs_pkg::RST_IRQ;
         irq_r     <= 1'b0;
         ack_r     <= 1'b0;
         dat_r     <= 32'h0000_0000;
      end else begin
         max_len_r <= max_len_nxt;
         min_len_r <= min_len_nxt;
         irq_st_r  <= irq_st_nxt;
         irq_msk_r <= irq_msk_nxt;
         irq_r     <= irq_nxt;
         ack_r     <= ack_nxt;
         dat_r     <= dat_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign fifo_err    = fifo_err_r;
   assign total_pkts  = total_r;
   assign good_pkts   = good_r;
   assign total_bytes = tbytes_r;
   assign good_bytes  = gbytes_r;
   assign small_pkts  = small_r;
   assign jabber      = jabber_r;
   assign large_pkts  = large_r;
   assign oversize    = over_r;
   assign undersize   = under_r;
   assign toolong     = long_r;
   assign fragment    = frag_r;
   assign hist_inc    = hist_r;
   assign irq         = irq_r;
   assign wb_dat_o    = dat_r;
   assign wb_ack_o    = ack_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_quiet;
      !rx_eop0 && !rx_eop1;
   endsequence

   sequence s_long_good;
      rx_eop0 && rx_len0 > max_len_r && rx_len0 >= 14'h0010 && !rx_fcs_bad0;
   endsequence

   sequence s_long_bad;
      rx_eop0 && rx_len0 > max_len_r && rx_len0 >= 14'h0010 && rx_fcs_bad0;
   endsequence

   chk_fifo_flag_up: assert property ((rx_fifo_ovf || rx_fifo_unf) |=> fifo_err == !MAC_BUILD) // [R1] [R17]
      else $error("buffer error flag wrong");

   chk_fifo_flag_hold: assert property (fifo_err |=> fifo_err [*3]) // [R2]
      else $error("buffer error flag dropped before reset");

   chk_total_count: assert property (MAC_BUILD |=> total_pkts ==
         2'($past(rx_eop0 && rx_len0 >= 14'h0010)) + 2'($past(rx_eop1 && rx_len1 >= 14'h0010))) // [R3] [R7]
      else $error("total packet increment wrong");

   chk_good_cause: assert property (good_pkts |-> $past(rx_eop0 && !rx_fcs_bad0 && !rx_err0)) // [R4]
      else $error("good pulse without a clean packet");

   chk_bytes_follow: assert property (##1 total_bytes == (MAC_BUILD ? $past(rx_bytes) : 6'h00)) // [R5]
      else $error("byte increment wrong");

   chk_good_bytes: assert property (good_bytes == (good_pkts ? $past(rx_len0) : 14'h0000)) // [R6]
      else $error("good byte increment wrong");

   chk_small_drop: assert property ((rx_eop0 && rx_len0 < 14'h0010 && !rx_eop1) |=>
         total_pkts == 2'h0 && small_pkts == 2'h0) // [R7]
      else $error("short packet not dropped");

   chk_long_split: assert property (toolong == (jabber || oversize) && !(jabber && oversize)) // [R8] [R10] [R12]
      else $error("too-long split wrong");

   chk_oversize_seq: assert property ((MAC_BUILD and s_long_good) |=> oversize && toolong && !jabber) // [R10]
      else $error("oversize not flagged");

   chk_jabber_seq: assert property ((MAC_BUILD and s_long_bad) |=> jabber && toolong && !oversize) // [R8] [R12]
      else $error("jabber not flagged");

   chk_large_fwd: assert property ((MAC_BUILD && rx_eop0 && rx_len0 > 14'h23FF) |=> large_pkts) // [R9]
      else $error("large pulse missing");

   chk_large_pkt: assert property (large_pkts |-> $past(rx_len0) > 14'h23FF) // [R9]
      else $error("large pulse on a short packet");

   chk_under_frag: assert property (!((|undersize) && (|fragment) && !$past(rx_eop1))) // [R11] [R13]
      else $error("one packet is both undersize and fragment");

   chk_hist_onehot: assert property ($onehot0(hist_inc) && (hist_inc[0] -> $past(rx_len0) == 14'h0040)) // [R14] [R15] [R16] [R19]
      else $error("histogram bins overlap");

   chk_quiet_zero: assert property (s_quiet |=> total_pkts == 2'h0 && hist_inc == 8'h00 && !toolong) // [R18]
      else $error("increment without an event");

   chk_irq_level: assert property (irq == |(irq_st_r & irq_msk_r))
      else $error("interrupt level wrong");

endmodule

//--- rxs_pkg.sv
// constants for the receive statistics increment generator
// What this block does
// R1 - flag high when the receive buffer underflows or overflows
// R2 - outside logic resets the port after seeing the buffer error flag
// R3 - two-bit count of packets ending this cycle, errors included
// R4 - good-packet pulse only for a complete packet with no error
// R5 - six-bit count of bytes received this cycle, all packets
// R6 - good-byte increment carries the length of a good packet only
// R7 - count packets under 64 bytes; drop packets under 16 bytes
// R8 - jabber pulse for packets above maximum length with bad check sequence
// R9 - large pulse for packets longer than 9,215 bytes
// R10 - oversize pulse for packets above maximum length with good check sequence
// R11 - undersize count for packets below minimum length with good check sequence
// R12 - too-long pulse for packets above maximum length, any check sequence
// R13 - fragment count for packets below minimum length with bad check sequence
// R14 - histogram pulses for 64, 65-127 and 128-255 byte packets
// R15 - histogram pulses for 256-511 and 512-1,023 byte packets
// R16 - histogram pulses for 1,024-1,518 and 1,519-1,522 byte packets
// R17 - buffer error flag in the PCS-only build, statistics in the MAC build
// R18 - every increment is zero unless an event, and lasts one cycle; fifo_err in the PCS-only build holds until reset
// R19 - histogram pulse for 1,523-1,548 byte packets
package rxs_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int unsigned LEN_W    = 14;
   localparam int unsigned BYTE_W   = 6;
   localparam int unsigned MIN_W    = 8;
   localparam int unsigned IRQ_W    = 5;
   localparam int unsigned HIST_N   = 8;

   // ----------------------------------------
   // packet length limits
   // ----------------------------------------
   localparam logic [13:0] DROP_LEN  = 14'h0010;
   localparam logic [13:0] SMALL_LEN = 14'h0040;
   localparam logic [13:0] LARGE_LEN = 14'h23FF;

   localparam logic [13:0] HIST_LO [0:7] = '{14'h0040, 14'h0041, 14'h0080, 14'h0100,
                                             14'h0200, 14'h0400, 14'h05EF, 14'h05F3};
   localparam logic [13:0] HIST_HI [0:7] = '{14'h0040, 14'h007F, 14'h00FF, 14'h01FF,
                                             14'h03FF, 14'h05EE, 14'h05F2, 14'h060C};

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADR_MAX_LEN = 8'h00;
   localparam logic [7:0] ADR_MIN_LEN = 8'h04;
   localparam logic [7:0] ADR_IRQ_ST  = 8'h08;
   localparam logic [7:0] ADR_IRQ_MSK = 8'h0C;

   localparam logic [13:0] RST_MAX_LEN = 14'h05EE;
   localparam logic [7:0]  RST_MIN_LEN = 8'h40;
   localparam logic [4:0]  RST_IRQ     = 5'h00;

   // interrupt status bit positions
   localparam int unsigned IRQ_FIFO  = 0;
   localparam int unsigned IRQ_JAB   = 1;
   localparam int unsigned IRQ_LONG  = 2;
   localparam int unsigned IRQ_FRAG  = 3;
   localparam int unsigned IRQ_UNDER = 4;

endpackage

//--- rxs_cnt_model.sv
// user counter logic that accumulates the increment pulses
module rxs_cnt_model (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic [1:0]  total_pkts,
   input  wire logic        good_pkts,
   input  wire logic [5:0]  total_bytes,
   input  wire logic [13:0] good_bytes,
   input  wire logic        fifo_err,
   output logic [31:0]      sum_pkts,
   output logic [31:0]      sum_good,
   output logic [31:0]      sum_bytes,
   output logic [31:0]      sum_gbytes,
   output logic             port_rst_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // accumulators
   // ----------------------------------------
   // increments add every cycle; no handshake, so a missed pulse is lost for good
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sum_pkts   <= 32'h0000_0000;
         sum_good   <= 32'h0000_0000;
         sum_bytes  <= 32'h0000_0000;
         sum_gbytes <= 32'h0000_0000;
      end else begin
         sum_pkts   <= sum_pkts + 32'(total_pkts);
         sum_good   <= sum_good + 32'(good_pkts);
         sum_bytes  <= sum_bytes + 32'(total_bytes);
         sum_gbytes <= sum_gbytes + 32'(good_bytes);
      end
   end
   // buffer state is lost once the flag is seen, so the port must be reset
   assign port_rst_req = fifo_err;
endmodule

//--- rxs_stats_gen_tb.sv
// self-checking bench for the receive statistics increment generator
module rxs_stats_gen_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // signals and case table
   // ----------------------------------------
   typedef struct packed {
      logic [13:0] l0;
      logic [11:0] fl;   // nibbles: bad check 0, other error 0, bad check 1
      logic [13:0] l1;
      logic [31:0] ex;   // nibbles: total, good, small, under, frag, {large,jab,over,long}, hist
   } rxs_row_t;
   logic        sys_clk = 1'b0, arst_n = 1'b0, pcs_rst_n = 1'b0;
   logic        rx_eop0 = 1'b0, rx_fcs_bad0 = 1'b0, rx_err0 = 1'b0, rx_eop1 = 1'b0, rx_fcs_bad1 = 1'b0;
   logic        rx_err1 = 1'b0, rx_fifo_ovf = 1'b0, rx_fifo_unf = 1'b0;
   logic [5:0]  rx_bytes = 6'h00, prev_by = 6'h00;
   logic [13:0] rx_len0 = 14'h0000, rx_len1 = 14'h0000;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0, sel_v = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic        fifo_err, good_pkts, jabber, large_pkts, oversize, toolong, irq, wb_ack_o, pcs_fifo, port_rst_req;
   logic [1:0]  total_pkts, small_pkts, undersize, fragment, pcs_tot;
   logic [5:0]  total_bytes;
   logic [13:0] good_bytes;
   logic [7:0]  hist_inc;
   logic [31:0] wb_dat_o, q, sum_pkts, sum_good, sum_bytes, sum_gbytes;
   int          err_total = 0, num_checks = 0, s_pkts = 0, s_good = 0, s_bytes = 0, s_gb = 0;
   rxs_row_t    prev = '0, zero_row = '0;
   rxs_row_t    rows [23] = '{
      '{14'h0040, 12'h000, 14'h0000, 32'h1100_0001}, '{14'h0041, 12'h000, 14'h0000, 32'h1100_0002},
      '{14'h007F, 12'h100, 14'h0000, 32'h1000_0002}, '{14'h0080, 12'h010, 14'h0000, 32'h1000_0004},
      '{14'h00FF, 12'h000, 14'h0000, 32'h1100_0004}, '{14'h0100, 12'h000, 14'h0000, 32'h1100_0008},
      '{14'h0200, 12'h000, 14'h0000, 32'h1100_0010}, '{14'h0400, 12'h000, 14'h0000, 32'h1100_0020},
      '{14'h05EE, 12'h000, 14'h0000, 32'h1100_0020}, '{14'h05EF, 12'h000, 14'h0000, 32'h1000_0340},
      '{14'h05F2, 12'h100, 14'h0000, 32'h1000_0540}, '{14'h05F3, 12'h000, 14'h0000, 32'h1000_0380},
      '{14'h060C, 12'h000, 14'h0000, 32'h1000_0380}, '{14'h060D, 12'h000, 14'h0000, 32'h1000_0300},
      '{14'h23FF, 12'h100, 14'h0000, 32'h1000_0500}, '{14'h2400, 12'h000, 14'h0000, 32'h1000_0B00},
      '{14'h003F, 12'h000, 14'h0000, 32'h1011_0000}, '{14'h003F, 12'h100, 14'h0000, 32'h1010_1000},
      '{14'h0010, 12'h000, 14'h0000, 32'h1011_0000}, '{14'h000F, 12'h000, 14'h0000, 32'h0000_0000},
      '{14'h0064, 12'h001, 14'h0014, 32'h2110_1002}, '{14'h001E, 12'h000, 14'h0028, 32'h2022_0000},
      '{14'h000F, 12'h001, 14'h0010, 32'h1010_1000}};

   always #4 sys_clk = ~sys_clk;

   rxs_stats_gen #(.MAC_BUILD(1'b1)) rxs_stats_gen_inst (.sys_clk, .arst_n, .rx_bytes, .rx_eop0, .rx_len0,
      .rx_fcs_bad0, .rx_err0, .rx_eop1, .rx_len1, .rx_fcs_bad1, .rx_err1, .rx_fifo_ovf, .rx_fifo_unf, .fifo_err,
      .total_pkts, .good_pkts, .total_bytes, .good_bytes, .small_pkts, .jabber, .large_pkts, .oversize, .undersize,
      .toolong, .fragment, .hist_inc, .irq, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o);
   // second build shares every input but the reset; only the buffer flag and one count are watched
   rxs_stats_gen #(.MAC_BUILD(1'b0)) rxs_stats_gen_pcs_inst (.sys_clk, .arst_n(pcs_rst_n), .rx_bytes,
      .rx_eop0, .rx_len0, .rx_fcs_bad0, .rx_err0, .rx_eop1, .rx_len1, .rx_fcs_bad1, .rx_err1, .rx_fifo_ovf,
      .rx_fifo_unf, .fifo_err(pcs_fifo), .total_pkts(pcs_tot), .good_pkts(), .total_bytes(), .good_bytes(),
      .small_pkts(), .jabber(), .large_pkts(), .oversize(), .undersize(), .toolong(), .fragment(), .hist_inc(),
      .irq(), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(), .wb_ack_o());
   rxs_cnt_model rxs_cnt_model_inst (.sys_clk, .arst_n, .total_pkts, .good_pkts, .total_bytes, .good_bytes,
      .fifo_err(pcs_fifo), .sum_pkts, .sum_good, .sum_bytes, .sum_gbytes, .port_rst_req);

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= sel_v;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic exp_chk(input rxs_row_t r, input logic [5:0] by);
      chk("total_pkts", 32'(total_pkts), 32'(r.ex[29:28]));
      chk("good_pkts", 32'(good_pkts), 32'(r.ex[24]));
      chk("total_bytes", 32'(total_bytes), 32'(by));
      chk("good_bytes", 32'(good_bytes), r.ex[24] ? 32'(r.l0) : 32'h0000_0000);
      chk("small_pkts", 32'(small_pkts), 32'(r.ex[21:20]));
      chk("undersize", 32'(undersize), 32'(r.ex[17:16]));
      chk("fragment", 32'(fragment), 32'(r.ex[13:12]));
      chk("large_pkts", 32'(large_pkts), 32'(r.ex[11]));
      chk("jabber", 32'(jabber), 32'(r.ex[10]));
      chk("oversize", 32'(oversize), 32'(r.ex[9]));
      chk("toolong", 32'(toolong), 32'(r.ex[8]));
      chk("hist_inc", 32'(hist_inc), 32'(r.ex[7:0]));
      chk("pcs_total", 32'(pcs_tot), 32'h0000_0000);
      s_pkts += int'(r.ex[29:28]);
      s_good += int'(r.ex[24]);
      s_bytes += int'(by);
      s_gb += r.ex[24] ? int'(r.l0) : 0;
   endtask

   // drives one cycle of packet ends and checks the cycle driven before, so rows run back to back
   task automatic step(input rxs_row_t r, input logic [5:0] by);
      @(posedge sys_clk);
      rx_eop0     <= r.l0 != 14'h0000;
      rx_len0     <= r.l0;
      rx_fcs_bad0 <= r.fl[8];
      rx_err0     <= r.fl[4];
      rx_eop1     <= r.l1 != 14'h0000;
      rx_len1     <= r.l1;
      rx_fcs_bad1 <= r.fl[0];
      rx_bytes    <= by;
      @(negedge sys_clk);
      exp_chk(prev, prev_by);
      prev = r;
      prev_by = by;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      arst_n    <= 1'b1;
      pcs_rst_n <= 1'b1;
      foreach (rows[i]) step(rows[i], 6'(i * 3 + 1));
      step(zero_row, 6'h00);
      step(zero_row, 6'h00);
      chk("idle", 32'(|{total_pkts, good_pkts, total_bytes, good_bytes, hist_inc, toolong}), 32'h0000_0000);
      chk("irq_masked", 32'(irq), 32'h0000_0000);
      wb_xfer(1'b0, 8'h00, 32'h0000_0000, q);
      chk("max_len", q, 32'h0000_05EE);
      wb_xfer(1'b0, 8'h04, 32'h0000_0000, q);
      chk("min_len", q, 32'h0000_0040);
      wb_xfer(1'b0, 8'h10, 32'h0000_0000, q);
      chk("unmapped", q, 32'h0000_0000);
      wb_xfer(1'b0, 8'h08, 32'h0000_0000, q);
      chk("status", q, 32'h0000_001E);
      wb_xfer(1'b1, 8'h0C, 32'h0000_0004, q);
      @(negedge sys_clk);
      chk("irq_on", 32'(irq), 32'h0000_0001);
      wb_xfer(1'b1, 8'h08, 32'h0000_001E, q);
      wb_xfer(1'b0, 8'h08, 32'h0000_0000, q);
      chk("status_clr", q, 32'h0000_0000);
      chk("irq_off", 32'(irq), 32'h0000_0000);
      wb_xfer(1'b1, 8'h00, 32'h0000_0064, q);
      wb_xfer(1'b1, 8'h04, 32'h0000_0020, q);
      step('{14'h0065, 12'h000, 14'h0000, 32'h1000_0302}, 6'h3F);
      step('{14'h0064, 12'h000, 14'h0000, 32'h1100_0002}, 6'h20);
      step('{14'h001F, 12'h000, 14'h0000, 32'h1011_0000}, 6'h01);
      step('{14'h0020, 12'h000, 14'h0000, 32'h1110_0000}, 6'h02);
      step(zero_row, 6'h00);
      step(zero_row, 6'h00);
      chk("irq_event", 32'(irq), 32'h0000_0001);
      // only the low byte lane is enabled, so the upper length bits keep their old value
      sel_v = 4'h1;
      wb_xfer(1'b1, 8'h00, 32'hFFFF_FF80, q);
      sel_v = 4'hF;
      wb_xfer(1'b0, 8'h00, 32'h0000_0000, q);
      chk("max_len_lane", q, 32'h0000_0080);
      @(posedge sys_clk);
      rx_fifo_ovf <= 1'b1;
      @(posedge sys_clk);
      rx_fifo_ovf <= 1'b0;
      @(negedge sys_clk);
      chk("fifo_err_ovf", 32'(pcs_fifo), 32'h0000_0001);
      chk("fifo_err_mac", 32'(fifo_err), 32'h0000_0000);
      chk("reset_request", 32'(port_rst_req), 32'h0000_0001);
      @(posedge sys_clk);
      pcs_rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      pcs_rst_n <= 1'b1;
      @(negedge sys_clk);
      chk("fifo_err_rst", 32'(pcs_fifo), 32'h0000_0000);
      @(posedge sys_clk);
      rx_fifo_unf <= 1'b1;
      @(posedge sys_clk);
      rx_fifo_unf <= 1'b0;
      @(negedge sys_clk);
      chk("fifo_err_unf", 32'(pcs_fifo), 32'h0000_0001);
      chk("sum_pkts", sum_pkts, 32'(s_pkts));
      chk("sum_good", sum_good, 32'(s_good));
      chk("sum_bytes", sum_bytes, 32'(s_bytes));
      chk("sum_gbytes", sum_gbytes, 32'(s_gb));
      final_report();
   end
endmodule
